/* core/rss_cfg.svh */
// register map, field positions, reset values and bus responses of the rotate/subtract/skip unit
// assumes a 32-bit AXI4-Lite slave with word-aligned registers
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RSS_OFF_CMD 8'h00
`define RSS_OFF_MEM 8'h04
`define RSS_OFF_WREG 8'h08
`define RSS_OFF_FLAGS 8'h0C
`define RSS_OFF_STAT 8'h10

// ----------------------------------------
// flag bit positions and flag field width
// ----------------------------------------
`define RSS_FLG_C 0
`define RSS_FLG_AUX 1
`define RSS_FLG_Z 2
`define RSS_FLG_OVF 3
`define RSS_FLG_SCMP 4
`define RSS_FLG_CZERO 5
`define RSS_FLG_W 6

// ----------------------------------------
// status bit positions
// ----------------------------------------
`define RSS_STAT_BUSY 0
`define RSS_STAT_SKIP 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define RSS_RST_BYTE 8'h00
`define RSS_RST_FLAGS 6'h00

// ----------------------------------------
// bus responses
// ----------------------------------------
`define RSS_RESP_OKAY 2'b00
`define RSS_RESP_SLVERR 2'b10

`endif

/* core/rss_pkg.sv */
// types shared by the rotate/subtract/skip unit
// assumes rss_cfg.svh provides the numeric constants
package rss_pkg;

  typedef enum logic [1:0] {
    RSS_OP_RRCA = 2'b00,
    RSS_OP_SBC = 2'b01,
    RSS_OP_SBCM = 2'b10,
    RSS_OP_SDZ = 2'b11
  } rss_op_e;

  typedef enum logic [1:0] {
    RSS_ST_IDLE = 2'b00,
    RSS_ST_EXEC = 2'b01,
    RSS_ST_NEXT = 2'b10,
    RSS_ST_DUMMY = 2'b11
  } rss_state_e;

endpackage

/* core/rss_ops.sv */
// rotate-through-carry, subtract-with-borrow and decrement-skip datapath
// assumes one 200 MHz clock, synchronous active-low reset, AXI4-Lite slave
// Functional notes
// - rotate right through carry: old carry to bit 7, bit 0 to carry
// - rotate result goes to working register only; memory unchanged, only carry changes
// - subtract with borrow: wreg minus operand minus inverted carry into wreg
// - carry cleared when true difference negative, set when zero or positive
// - memory variant does the same subtraction and writes result to memory
// - both subtract variants update overflow, zero, aux carry, carry, compare, carry-zero
// - decrement memory byte by one, write back, test zero, no flag changes
// - zero result inserts a dummy cycle: three cycles, else two
`timescale 1ns/1ps
`include "rss_cfg.svh"

module rss_ops
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic busy,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  output logic skip
);
  import rss_pkg::*;

  // ----------------------------------------
  // subtract-with-borrow flag function
  // ----------------------------------------
  // flags {carry-zero, compare, overflow, zero, aux carry, carry} above the result byte
  function automatic logic [13:0] sbc_calc(
    input logic [7:0] a,
    input logic [7:0] m,
    input logic cin,
    input logic zold
  );
    logic [8:0] diff;
    logic [4:0] nib;
    logic z;
    logic ovf;
    diff = {1'b0, a} - {1'b0, m} - {8'h00, ~cin};
    nib = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~cin};
    z = (diff[7:0] == 8'h00);
    ovf = (a[7] != m[7]) && (diff[7] != a[7]);
    sbc_calc = {z & zold, ovf ^ diff[7], ovf, z, ~nib[4], ~diff[8], diff[7:0]};
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  rss_state_e state_q;
  rss_state_e state_d;
  rss_op_e op_q;
  logic [7:0] mem_q;
  logic [7:0] wreg_q;
  logic [5:0] flags_q;
  logic skip_q;
  logic mem_we_q;
  logic [7:0] mem_wdata_q;
  logic skip_pulse_q;
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // ----------------------------------------
  // write channel decode
  // ----------------------------------------
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_ok = aw_have_q || aw_take;
  wire w_ok = w_have_q || w_take;
  wire do_wr = aw_ok && w_ok;
  wire [7:0] wr_addr = aw_have_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_have_q ? w_data_q : s_axi_wdata;
  wire [3:0] wr_strb = w_have_q ? w_strb_q : s_axi_wstrb;
  wire wr_lane0 = wr_strb[0];
  wire idle = (state_q == RSS_ST_IDLE);
  wire wr_cmd = do_wr && (wr_addr == `RSS_OFF_CMD);
  wire wr_mem = do_wr && (wr_addr == `RSS_OFF_MEM);
  wire wr_wreg = do_wr && (wr_addr == `RSS_OFF_WREG);
  wire wr_flags = do_wr && (wr_addr == `RSS_OFF_FLAGS);
  wire wr_stat = do_wr && (wr_addr == `RSS_OFF_STAT);
  wire wr_hit = wr_cmd || wr_mem || wr_wreg || wr_flags || wr_stat;
  // software writes only land while idle so operands stay stable
  wire sw_en = idle && wr_lane0;
  wire start = wr_cmd && sw_en;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ----------------------------------------
  // read channel decode
  // ----------------------------------------
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [31:0] stat_word = {30'h0000_0000, skip_q, !idle};
  wire rd_cmd = (s_axi_araddr == `RSS_OFF_CMD);
  wire rd_mem = (s_axi_araddr == `RSS_OFF_MEM);
  wire rd_wreg = (s_axi_araddr == `RSS_OFF_WREG);
  wire rd_flags = (s_axi_araddr == `RSS_OFF_FLAGS);
  wire rd_stat = (s_axi_araddr == `RSS_OFF_STAT);
  wire rd_hit = rd_cmd || rd_mem || rd_wreg || rd_flags || rd_stat;
  logic [31:0] rd_word;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (rd_cmd)
      rd_word = {30'h0000_0000, op_q};
    else if (rd_mem)
      rd_word = {24'h00_0000, mem_q};
    else if (rd_wreg)
      rd_word = {24'h00_0000, wreg_q};
    else if (rd_flags)
      rd_word = {26'h000_0000, flags_q};
    else if (rd_stat)
      rd_word = stat_word;
  end

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------
  // datapath
  // ----------------------------------------
  wire cin = flags_q[`RSS_FLG_C];
  wire [7:0] rot_res = {cin, mem_q[7:1]};
  wire [13:0] sbc = sbc_calc(wreg_q, mem_q, cin, flags_q[`RSS_FLG_Z]);
  wire [7:0] dec_res = mem_q - 8'h01;
  wire dec_zero = (dec_res == 8'h00);
  wire exec = (state_q == RSS_ST_EXEC);

  logic [7:0] wreg_d;
  logic [7:0] mem_d;
  logic [5:0] flags_d;
  logic mem_we_d;

  always_comb
  begin
    wreg_d = wreg_q;
    mem_d = mem_q;
    flags_d = flags_q;
    mem_we_d = 1'b0;
    if (exec)
    begin
      case (op_q)
        RSS_OP_RRCA:
        begin
          wreg_d = rot_res;
          flags_d[`RSS_FLG_C] = mem_q[0];
        end
        RSS_OP_SBC:
        begin
          wreg_d = sbc[7:0];
          flags_d = sbc[13:8];
        end
        RSS_OP_SBCM:
        begin
          mem_d = sbc[7:0];
          mem_we_d = 1'b1;
          flags_d = sbc[13:8];
        end
        default:
        begin
          mem_d = dec_res;
          mem_we_d = 1'b1;
        end
      endcase
    end
    else if (sw_en)
    begin
      if (wr_mem)
        mem_d = wr_data[7:0];
      else if (wr_wreg)
        wreg_d = wr_data[7:0];
      else if (wr_flags)
        flags_d = wr_data[`RSS_FLG_W-1:0];
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // two cycles per operation; a zero decrement adds the dummy slot
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      RSS_ST_IDLE:
        if (start)
          state_d = RSS_ST_EXEC;
      RSS_ST_EXEC:
        state_d = RSS_ST_NEXT;
      RSS_ST_NEXT:
        if (skip_q)
          state_d = RSS_ST_DUMMY;
        else
          state_d = RSS_ST_IDLE;
      default:
        state_d = RSS_ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= RSS_ST_IDLE;
      op_q <= RSS_OP_RRCA;
      mem_q <= `RSS_RST_BYTE;
      wreg_q <= `RSS_RST_BYTE;
      flags_q <= `RSS_RST_FLAGS;
      skip_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_wdata_q <= `RSS_RST_BYTE;
      skip_pulse_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      mem_q <= mem_d;
      wreg_q <= wreg_d;
      flags_q <= flags_d;
      mem_we_q <= mem_we_d;
      if (mem_we_d)
        mem_wdata_q <= mem_d;
      if (start)
        op_q <= rss_op_e'(wr_data[1:0]);
      if (start)
        skip_q <= 1'b0;
      else if (exec)
        skip_q <= (op_q == RSS_OP_SDZ) && dec_zero;
      skip_pulse_q <= (state_d == RSS_ST_DUMMY);
    end
  end

  assign busy = !idle;
  assign mem_we = mem_we_q;
  assign mem_wdata = mem_wdata_q;
  assign skip = skip_pulse_q;

  // ----------------------------------------
  // bus handshake registers
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RSS_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RSS_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
        aw_addr_q <= s_axi_awaddr;
      if (w_take)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      aw_have_q <= aw_ok && !do_wr;
      w_have_q <= w_ok && !do_wr;
      if (do_wr)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `RSS_RESP_OKAY : `RSS_RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
      if (ar_take)
      begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? `RSS_RESP_OKAY : `RSS_RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

endmodule

/* testbench/rss_ops_props.sv */
// timing checks on the unit's outer ports
// assumes it is bound onto rss_ops, one clock domain
`timescale 1ns/1ps
module rss_ops_props
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_arready,
  input wire logic busy,
  input wire logic mem_we,
  input wire logic skip
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  op_len_a: assert property ($rose(busy) |-> busy[*2] ##1 (!busy || skip))
    else $error("operation length wrong");
  skip_end_a: assert property (skip |-> busy ##1 !busy && !skip)
    else $error("dummy cycle wrong");
  skip_after_a: assert property (skip |-> $past(mem_we))
    else $error("skip before write back");
  we_pulse_a: assert property (mem_we |-> busy ##1 !mem_we)
    else $error("memory write not one pulse");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  read_one_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
  we_window_a: assert property (mem_we |-> $past(busy) && !$past(busy, 2))
    else $error("memory write misplaced");
endmodule

bind rss_ops rss_ops_props u_props (.aclk(aclk), .aresetn(aresetn), .busy(busy),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_arready(s_axi_arready), .mem_we(mem_we), .skip(skip));

/* testbench/rss_mem_model.sv */
// stand-in data memory taking the unit's write strobes
// assumes the unit's clock
`timescale 1ns/1ps
module rss_mem_model
(
  input wire logic aclk,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  output int n_writes,
  output logic [7:0] last_byte
);
  initial n_writes = 0;
  initial last_byte = 8'h00;
  always @(posedge aclk)
    if (mem_we)
    begin
      n_writes <= n_writes + 1;
      last_byte <= mem_wdata;
    end
endmodule

/* testbench/rotate_subtract_skip_ops_bench.sv */
// self-checking bench for the rotate/subtract/skip unit
// assumes rss_cfg.svh on the include path
`timescale 1ns/1ps
`include "rss_cfg.svh"
module rotate_subtract_skip_ops_bench;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, busy, mem_we, skip;
  logic [7:0] awaddr, araddr, mem_wdata, last_byte;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int fail_count = 0;
  int n_compared = 0;
  int n_writes;
  int busy_len = 0;
  int last_len = 0;
  int n_runs = 0;
  int n_skips = 0;
  logic [1:0] last_bresp;
  rss_ops u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .busy(busy), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .skip(skip));
  rss_mem_model u_mem (.aclk(aclk), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .n_writes(n_writes), .last_byte(last_byte));
  // busy run length taken as the run closes, independent of bus latency
  always @(posedge aclk)
  begin
    if (skip === 1'b1)
      n_skips <= n_skips + 1;
    if (busy === 1'b1)
      busy_len <= busy_len + 1;
    else if (busy_len != 0)
    begin
      last_len <= busy_len;
      n_runs <= n_runs + 1;
      busy_len <= 0;
    end
  end
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ready raised one cycle late so the response hold is exercised
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        last_bresp = bresp;
        break;
      end
      bready <= bvalid;
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      rready <= rvalid;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, exp, input logic [7:0] m = 8'hFF);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(what, d[7:0] & m, exp);
    chk("rresp", r, `RSS_RESP_OKAY);
  endtask
  task automatic run_op(input logic [1:0] op, output int c, output logic s);
    int k0, r0;
    k0 = n_skips;
    r0 = n_runs;
    wr(`RSS_OFF_CMD, {6'h00, op});
    repeat (8)
    begin
      @(posedge aclk);
      if (busy !== 1'b1) break;
    end
    // one more edge so the run counter has closed the run
    @(posedge aclk);
    c = (n_runs != r0) ? last_len : 0;
    s = (n_skips != k0);
  endtask
  task automatic op_case(input logic [1:0] op, input logic [7:0] w, m, f, res, ef);
    int c, n0;
    logic s;
    logic [7:0] lb0;
    wr(`RSS_OFF_WREG, w);
    wr(`RSS_OFF_MEM, m);
    wr(`RSS_OFF_FLAGS, f);
    n0 = n_writes;
    lb0 = last_byte;
    run_op(op, c, s);
    chk("cycles", c, 2);
    chk("bresp", last_bresp, `RSS_RESP_OKAY);
    rchk("wreg", `RSS_OFF_WREG, op == 2'd2 ? w : res);
    rchk("mem", `RSS_OFF_MEM, op == 2'd2 ? res : m);
    rchk("flags", `RSS_OFF_FLAGS, ef, 8'h3F);
    chk("mem writes", n_writes - n0, op == 2'd2);
    chk("mem port", last_byte, op == 2'd2 ? res : lb0);
    $display("op %0d case done", op);
  endtask
  task automatic dec_case(input logic [7:0] m, input logic sk);
    int c;
    logic s;
    logic [7:0] e;
    e = m - 8'h01;
    wr(`RSS_OFF_MEM, m);
    wr(`RSS_OFF_FLAGS, 8'h15);
    run_op(2'd3, c, s);
    chk("cycles", c, 2 + sk);
    chk("skip", s, sk);
    chk("mem port", last_byte, e);
    rchk("mem", `RSS_OFF_MEM, e);
    rchk("flags", `RSS_OFF_FLAGS, 8'h15, 8'h3F);
    rchk("status", `RSS_OFF_STAT, {6'h00, sk, 1'b0});
    $display("decrement case done");
  endtask
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rchk("wreg", `RSS_OFF_WREG, 8'h00);
    rchk("flags", `RSS_OFF_FLAGS, 8'h00, 8'h3F);
    rd(8'h14, d, r);
    chk("unmapped", {r, d[29:0]}, 32'h8000_0000);
    wr(8'h14, 8'h00);
    chk("unmapped write", last_bresp, `RSS_RESP_SLVERR);
    $display("reset case done");
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial
  begin
    #100000;
    fail_count++;
    finish_test();
  end
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0000_0000_0000;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    op_case(2'd0, 8'h00, 8'h81, 8'h3E, 8'h40, 8'h3F);
    op_case(2'd0, 8'h00, 8'h02, 8'h3F, 8'h81, 8'h3E);
    op_case(2'd1, 8'h80, 8'h01, 8'h01, 8'h7F, 8'h19);
    op_case(2'd1, 8'h10, 8'h20, 8'h01, 8'hF0, 8'h12);
    op_case(2'd2, 8'h30, 8'h2F, 8'h04, 8'h00, 8'h25);
    dec_case(8'h02, 1'b0);
    dec_case(8'h01, 1'b1);
    dec_case(8'h00, 1'b0);
    finish_test();
  end
endmodule
